// *** hw/fcdu_top.sv ***
// float convert, divide and string fill execution unit with avalon-mm registers
// Behaviour
// RULE1: single to double widening, invalid flag only
// RULE2: same source and destination register still correct
// RULE3: single to word uses status word rounding
// RULE4: infinity, nan, out of range give invalid
// RULE5: inexact in-range conversion sets inexact and traps
// RULE6: word conversion trap keeps pc, destination undefined
// RULE7: truncating conversions always round toward zero
// RULE8: word to double exact, never traps
// RULE9: word to single rounds, flags inexact, traps
// RULE10: double divide, second over first, five flags
// RULE11: single divide like double, same flags
// RULE12: divide or widen trap keeps pc, destination
// RULE13: signed divide, sign rule, clear flags, zero traps
// RULE14: overflow only for most negative over minus one
// RULE15: signed quotient truncates, consistent with remainder
// RULE16: unsigned divide, flags cleared, zero divisor traps
// RULE17: fill takes count, address, pattern registers
// RULE18: fill stores low byte, steps, rotates eight
// RULE19: software replicates fill value in pattern
// RULE20: fill trap leaves registers restartable
// RULE21: fill reports store faults, zero count stores nothing
module fcdu_top
  import fcdu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [31:0] mem_address,
  output logic      [7:0]  mem_byte,
  output logic             mem_write,
  input  wire logic        mem_waitrequest,
  input  wire logic [1:0]  mem_fault
);
  // ==========================================================================
  // helper functions
  function automatic fcdu_unp_type unpack(input logic [63:0] v, input logic dbl);
    fcdu_unp_type u;
    logic [10:0]  ef;
    logic [51:0]  fr;
    logic         ones;
    ef = dbl ? v[62:52] : {3'h0, v[30:23]};
    fr = dbl ? v[51:0] : {v[22:0], 29'h0};
    ones = dbl ? (ef == 11'h7FF) : (ef == 11'h0FF);
    u.sign = dbl ? v[63] : v[31];
    u.sig = {ef != 11'h0, fr, 3'h0};
    u.exp = $signed({3'h0, (ef == 11'h0) ? 11'h1 : ef}) - (dbl ? BIAS_D : BIAS_S);
    u.zero = (ef == 11'h0) && (fr == 52'h0);
    u.inf = ones && (fr == 52'h0);
    u.nan = ones && (fr != 52'h0);
    u.snan = u.nan && !fr[51];
    return u;
  endfunction

  // rounding increment for a given mode, sign, lsb, guard and sticky
  function automatic logic rinc(input logic [1:0] rm, input logic s, input logic lsb,
                                input logic g, input logic st);
    logic r;
    case (rm)
      RM_NEAR: r = g & (st | lsb);
      RM_UP:   r = ~s & (g | st);
      RM_DOWN: r = s & (g | st);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // round and pack; result is {inexact, overflow, underflow, value}
  function automatic logic [66:0] rpack(input logic s, input logic signed [13:0] e,
                                        input logic [55:0] sg, input logic stk,
                                        input logic dbl, input logic [1:0] rm);
    logic signed [13:0] emin;
    logic signed [13:0] dn;
    logic signed [13:0] bz;
    logic [6:0]         t;
    logic [63:0]        m;
    logic [63:0]        mm;
    logic [53:0]        r;
    logic [63:0]        v;
    logic               den;
    logic               g;
    logic               st;
    logic               cy;
    logic               ov;
    logic               toinf;
    emin = dbl ? EMIN_D : EMIN_S;
    den = e < emin;
    dn = emin - e;
    t = (dbl ? 7'd0 : 7'd29) + (den ? ((dn > 14'sd63) ? 7'd63 : dn[6:0]) : 7'd0);
    if (t > 7'd63) t = 7'd63;
    m = {sg, 8'h00};
    mm = m >> t;
    g = mm[10];
    st = (|mm[9:0]) | (|(m << (7'd64 - t))) | stk;
    r = {1'b0, mm[63:11]} + {53'h0, rinc(rm, s, mm[11], g, st)};
    cy = dbl ? r[53] : r[24];
    if (cy) r = r >> 1;
    if (den) bz = {13'h0, dbl ? r[52] : r[23]};
    else bz = e + {13'h0, cy} + (dbl ? BIAS_D : BIAS_S);
    ov = ~den & (bz >= (dbl ? EMAXF_D : EMAXF_S));
    toinf = (rm == RM_NEAR) | ((rm == RM_UP) & ~s) | ((rm == RM_DOWN) & s);
    if (ov && dbl) v = toinf ? {s, 11'h7FF, 52'h0} : {s, 11'h7FE, {52{1'b1}}};
    else if (ov) v = toinf ? {32'h0, s, 8'hFF, 23'h0} : {32'h0, s, 8'hFE, {23{1'b1}}};
    else if (dbl) v = {s, bz[10:0], r[51:0]};
    else v = {32'h0, s, bz[7:0], r[22:0]};
    return {g | st | ov, ov, den & (g | st), v};
  endfunction

  // ==========================================================================
  // state and software-visible registers
  fcdu_state_type st;
  fcdu_unp_type   ua;
  fcdu_unp_type   ub;
  logic [3:0]     op;
  logic [1:0]     rm_eff;
  logic [56:0]    rem;
  logic [55:0]    qt;
  logic [6:0]     cnt;
  logic [31:0]    op_a_lo;
  logic [31:0]    op_a_hi;
  logic [31:0]    op_b_lo;
  logic [31:0]    op_b_hi;
  logic [63:0]    res;
  logic [1:0]     processor_status_word;
  logic [4:0]     flags;
  logic [4:0]     trap_en;
  logic [31:0]    insn_pc;
  logic [31:0]    fp_pc;
  logic [63:0]    fp_dest;
  logic [31:0]    fill_count;
  logic [31:0]    fill_addr;
  logic [31:0]    fill_pat;
  logic           trap;
  logic [8:0]     cause;
  logic [3:0]     cond;
  logic           rd_done;

  // ==========================================================================
  // bus decode
  wire logic [4:0] idx = avs_address[6:2];
  wire logic busy = st != ST_IDLE;
  // writes stall while busy so operands and fill registers never see two writers
  wire logic wr_ok = avs_write & ~busy;
  wire logic sel_cmd = idx == OFF_CMD[6:2];
  wire logic sel_flags = idx == OFF_FLAGS[6:2];
  wire logic start = wr_ok & sel_cmd & (avs_writedata[3:0] <= OP_INITC);
  wire logic [3:0] new_op = avs_writedata[3:0];
  assign avs_waitrequest = (avs_read & ~rd_done) | (avs_write & busy);

  wire logic [31:0] status = {15'h0, cause, cond, 2'h0, trap, busy};
  wire logic [31:0] rd_mux =
    sel_cmd                    ? status :
    (idx == OFF_OPA_LO[6:2])   ? op_a_lo :
    (idx == OFF_OPA_HI[6:2])   ? op_a_hi :
    (idx == OFF_OPB_LO[6:2])   ? op_b_lo :
    (idx == OFF_OPB_HI[6:2])   ? op_b_hi :
    (idx == OFF_RES_LO[6:2])   ? res[31:0] :
    (idx == OFF_RES_HI[6:2])   ? res[63:32] :
    (idx == OFF_PSW[6:2])      ? {30'h0, processor_status_word} :
    sel_flags                  ? {27'h0, flags} :
    (idx == OFF_TRAPEN[6:2])   ? {27'h0, trap_en} :
    (idx == OFF_PC[6:2])       ? insn_pc :
    (idx == OFF_FPPC[6:2])     ? fp_pc :
    (idx == OFF_FPD_LO[6:2])   ? fp_dest[31:0] :
    (idx == OFF_FPD_HI[6:2])   ? fp_dest[63:32] :
    (idx == OFF_FCOUNT[6:2])   ? fill_count :
    (idx == OFF_FADDR[6:2])    ? fill_addr :
    (idx == OFF_FPAT[6:2])     ? fill_pat : 32'h0;

  // ==========================================================================
  // operation start decode
  wire logic [63:0] opa = {op_a_hi, op_a_lo};
  wire logic a_dbl = (new_op == OP_CNVDW) | (new_op == OP_CNVTDW) | (new_op == OP_DIVD);
  wire logic new_int2f = (new_op == OP_CNVWD) | (new_op == OP_CNVWS);
  wire logic new_idiv = (new_op == OP_DIVW) | (new_op == OP_DIVWU);
  wire logic new_sgn = new_op == OP_DIVW;
  // magnitudes; the most negative word keeps its bit pattern as 2^31 unsigned
  wire logic [31:0] abs_a = (new_sgn | new_int2f) & op_a_lo[31] ? -op_a_lo : op_a_lo;
  wire logic [31:0] abs_b = new_sgn & op_b_lo[31] ? -op_b_lo : op_b_lo;
  fcdu_unp_type up_a;
  fcdu_unp_type up_b;
  always_comb begin
    up_a = unpack(opa, a_dbl);
    up_b = unpack({op_b_hi, op_b_lo}, new_op == OP_DIVD);
    if (new_int2f) begin
      up_a.sign = op_a_lo[31];
      up_a.exp = 14'sd31;
      up_a.sig = {abs_a, 24'h0};
      up_a.zero = op_a_lo == 32'h0;
      up_a.inf = 1'b0;
      up_a.nan = 1'b0;
      up_a.snan = 1'b0;
    end
    if (new_idiv) up_a.sig = {24'h0, abs_a};
  end
  // truncating conversions ignore the status word mode
  wire logic [1:0] new_rm = ((new_op == OP_CNVTSW) | (new_op == OP_CNVTDW)) ? RM_ZERO :
                            processor_status_word; // RULE3 RULE7

  // ==========================================================================
  // normalise and divide datapath
  wire logic norm_a = (ua.sig != 56'h0) & ~ua.sig[55];
  wire logic norm_b = (ub.sig != 56'h0) & ~ub.sig[55];
  wire logic is_fdiv = (op == OP_DIVD) | (op == OP_DIVS);
  wire logic is_idiv = (op == OP_DIVW) | (op == OP_DIVWU);
  // long division: shift one dividend bit in, subtract when the divisor fits
  wire logic [56:0] rem_sh = {rem[55:0], qt[55]};
  wire logic        q_bit = rem_sh >= {1'b0, ua.sig};
  wire logic [56:0] rem_nx = q_bit ? rem_sh - {1'b0, ua.sig} : rem_sh; // RULE10 RULE13
  wire logic signed [13:0] ediv = ub.exp - ua.exp;

  // ==========================================================================
  // rounding inputs: quotient for divides, source value for conversions
  wire logic               rp_s = is_fdiv ? ua.sign ^ ub.sign : ua.sign;
  wire logic signed [13:0] rp_e = is_fdiv ? (qt[55] ? ediv : ediv - 14'sd1) : ua.exp;
  wire logic [55:0]        rp_sg = is_fdiv ? (qt[55] ? qt : {qt[54:0], 1'b0}) : ua.sig;
  wire logic rp_dbl = (op == OP_DIVD) | (op == OP_CNVSD) | (op == OP_CNVWD);
  wire logic [66:0] rp = rpack(rp_s, rp_e, rp_sg, is_fdiv & (rem != 57'h0), rp_dbl, rm_eff);

  // float to word: align the significand so the binary point sits at bit 64
  wire logic signed [13:0] fi_d = 14'sd55 - ua.exp;
  wire logic [119:0] fi_x = {ua.sig, 64'h0} >> fi_d[6:0];
  wire logic fi_tiny = ua.exp < -14'sd1;
  wire logic fi_big = ua.exp > 14'sd31;
  wire logic [32:0] fi_mag = fi_tiny | fi_big ? 33'h0 : fi_x[96:64];
  wire logic fi_g = ~fi_tiny & fi_x[63];
  wire logic fi_st = fi_tiny ? (ua.sig != 56'h0) : (|fi_x[62:0]);
  wire logic [32:0] fi_mg = fi_mag + {32'h0, rinc(rm_eff, ua.sign, fi_mag[0], fi_g, fi_st)};
  wire logic [32:0] fi_lim = ua.sign ? {2'h0, INT_BAD[30:0] + 31'h0} + 33'h080000000
                                     : 33'h07FFFFFFF;
  wire logic fi_bad = fi_big | ua.nan | ua.inf | (fi_mg > fi_lim); // RULE4
  wire logic [31:0] fi_val = ua.sign ? 32'h0 - fi_mg[31:0] : fi_mg[31:0];

  // integer quotient sign: positive when operand signs agree
  wire logic [31:0] iq = qt[31:0];
  wire logic iq_neg = (op == OP_DIVW) & (op_a_lo[31] ^ op_b_lo[31]);
  wire logic idiv_ovf = (op == OP_DIVW) & (op_b_lo == INT_BAD) & (op_a_lo == 32'hFFFFFFFF);

  // ==========================================================================
  // completion: result, raised flags and trap decision
  logic [63:0] fin_res;
  logic [4:0]  fin_fl;
  logic        fin_div0;
  logic [3:0]  fin_cond;
  logic        fin_keep;
  wire logic   sq = ua.sign ^ ub.sign;
  wire logic   dz = ua.zero & ub.zero;
  wire logic   di = ua.inf & ub.inf;
  always_comb begin
    fin_res = {op_b_hi, op_b_lo};
    fin_fl = 5'h0;
    fin_div0 = 1'b0;
    fin_cond = 4'h0;
    fin_keep = 1'b1;
    case (op)
      OP_CNVSD: begin
        fin_fl[FL_I] = ua.snan; // RULE1
        if (ua.nan) fin_res = {ua.sign, 11'h7FF, 1'b1, ua.sig[53:3]};
        else if (ua.inf) fin_res = {ua.sign, 11'h7FF, 52'h0};
        else if (ua.zero) fin_res = {ua.sign, 63'h0};
        else fin_res = rp[63:0];
      end
      OP_CNVSW, OP_CNVTSW, OP_CNVDW, OP_CNVTDW: begin
        fin_keep = 1'b0; // RULE6
        fin_fl[FL_I] = fi_bad; // RULE4
        fin_fl[FL_X] = ~fi_bad & (fi_g | fi_st); // RULE5
        fin_res = {32'h0, fi_bad ? INT_BAD : fi_val};
      end
      OP_CNVWD: fin_res = ua.zero ? 64'h0 : rp[63:0]; // RULE8
      OP_CNVWS: begin
        fin_res = ua.zero ? 64'h0 : rp[63:0];
        fin_fl[FL_X] = ~ua.zero & rp[66]; // RULE9
      end
      OP_DIVD, OP_DIVS: begin
        if (ua.nan | ub.nan | dz | di) begin
          fin_fl[FL_I] = ua.snan | ub.snan | (~ua.nan & ~ub.nan); // RULE10 RULE11
          fin_res = rp_dbl ? QNAN_D : {32'h0, QNAN_S};
        end else if (ub.inf | ua.zero) begin
          fin_fl[FL_D] = ua.zero & ~ub.inf;
          fin_res = rp_dbl ? {sq, 11'h7FF, 52'h0} : {32'h0, sq, 8'hFF, 23'h0};
        end else if (ub.zero | ua.inf) begin
          fin_res = rp_dbl ? {sq, 63'h0} : {32'h0, sq, 31'h0};
        end else begin
          fin_fl[FL_X] = rp[66];
          fin_fl[FL_V] = rp[65];
          fin_fl[FL_U] = rp[64];
          fin_res = rp[63:0];
        end
      end
      default: begin
        // divide word: quotient truncates toward zero, matching remainder
        fin_keep = 1'b0;
        fin_div0 = op_a_lo == 32'h0; // RULE13 RULE16
        fin_cond[1] = idiv_ovf; // RULE14
        if (!fin_div0) fin_res = {op_b_hi, iq_neg ? 32'h0 - iq : iq}; // RULE15
      end
    endcase
  end
  wire logic fin_trap = (|(fin_fl & trap_en)) | fin_div0;

  // ==========================================================================
  // string fill handshake
  assign mem_write = (st == ST_FILL) & (fill_count != 32'h0); // RULE21
  wire logic st_done = mem_write & ~mem_waitrequest;
  wire logic st_fault = st_done & (mem_fault != MEM_OK);

  // ==========================================================================
  // bus read data: one wait cycle so read data always comes from a flop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_done <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_done <= avs_read & ~rd_done;
      if (avs_read & ~rd_done) avs_readdata <= rd_mux;
    end
  end

  // software-only registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_a_lo <= 32'h0;
      op_a_hi <= 32'h0;
      op_b_lo <= 32'h0;
      op_b_hi <= 32'h0;
      processor_status_word <= PSW_RM_RST;
      trap_en <= TRAPEN_RST;
      insn_pc <= 32'h0;
    end else if (wr_ok) begin
      if (idx == OFF_OPA_LO[6:2]) op_a_lo <= avs_writedata;
      if (idx == OFF_OPA_HI[6:2]) op_a_hi <= avs_writedata;
      if (idx == OFF_OPB_LO[6:2]) op_b_lo <= avs_writedata;
      if (idx == OFF_OPB_HI[6:2]) op_b_hi <= avs_writedata;
      if (idx == OFF_PSW[6:2]) processor_status_word <= avs_writedata[1:0];
      if (idx == OFF_TRAPEN[6:2]) trap_en <= avs_writedata[4:0];
      if (idx == OFF_PC[6:2]) insn_pc <= avs_writedata;
    end
  end

  // accrued flags: write one to clear, a flag raised in the same cycle stays set
  wire logic [4:0] flag_clr = (wr_ok & sel_flags) ? avs_writedata[4:0] : 5'h0;
  wire logic [4:0] flag_set = (st == ST_FIN) ? fin_fl : 5'h0;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) flags <= 5'h0;
    else flags <= (flags & ~flag_clr) | flag_set;
  end

  // sequencer: idle, normalise, divide loop, finish, string fill
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= ST_IDLE;
      op <= OP_CNVSD;
      rm_eff <= RM_NEAR;
      ua <= '0;
      ub <= '0;
      rem <= 57'h0;
      qt <= 56'h0;
      cnt <= 7'h0;
    end else begin
      case (st)
        ST_IDLE: if (start) begin
          // operands are latched here, so a shared source and destination is safe
          op <= new_op; // RULE2
          rm_eff <= new_rm;
          ua <= up_a;
          ub <= up_b;
          rem <= 57'h0;
          qt <= {24'h0, abs_b};
          cnt <= STEPS_INT;
          st <= (new_op == OP_INITC) ? ST_FILL : new_idiv ? ST_DIV : ST_NORM; // RULE17
        end
        ST_NORM: begin
          if (norm_a) begin
            ua.sig <= {ua.sig[54:0], 1'b0};
            ua.exp <= ua.exp - 14'sd1;
          end
          if (norm_b) begin
            ub.sig <= {ub.sig[54:0], 1'b0};
            ub.exp <= ub.exp - 14'sd1;
          end
          if (!norm_a && !norm_b) begin
            qt <= ub.sig;
            cnt <= STEPS_FLT;
            st <= is_fdiv ? ST_DIV : ST_FIN;
          end
        end
        ST_DIV: begin
          rem <= rem_nx;
          qt <= {qt[54:0], q_bit};
          cnt <= cnt - 7'd1;
          if (cnt == 7'd1) st <= ST_FIN;
        end
        ST_FIN: st <= ST_IDLE;
        default: if (fill_count == 32'h0 || st_fault) st <= ST_IDLE;
      endcase
    end
  end

  // results, status and floating trap context
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      res <= 64'h0;
      trap <= 1'b0;
      cause <= 9'h0;
      cond <= 4'h0;
      fp_pc <= 32'h0;
      fp_dest <= 64'h0;
    end else if (start) begin
      trap <= 1'b0;
      cause <= 9'h0;
    end else if (st == ST_FIN) begin
      res <= fin_res;
      trap <= fin_trap;
      cause <= {3'h0, fin_div0, fin_fl};
      cond <= fin_cond;
      if (fin_trap & ~fin_div0) begin
        fp_pc <= insn_pc; // RULE6 RULE12
        fp_dest <= fin_keep ? {op_b_hi, op_b_lo} : 64'h0; // RULE12
      end
    end else if (st_fault) begin
      trap <= 1'b1; // RULE21
      cause <= {mem_fault == 2'h3, mem_fault == 2'h2, mem_fault == 2'h1, 6'h0};
    end
  end

  // fill registers: software loads them, each store that completes without a fault advances them
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fill_count <= 32'h0;
      fill_addr <= 32'h0;
      fill_pat <= 32'h0;
    end else if (wr_ok) begin
      if (idx == OFF_FCOUNT[6:2]) fill_count <= avs_writedata;
      if (idx == OFF_FADDR[6:2]) fill_addr <= avs_writedata;
      if (idx == OFF_FPAT[6:2]) fill_pat <= avs_writedata;
    end else if (st_done && !st_fault) begin
      // a faulting store leaves all three untouched so a restart resumes here
      fill_count <= fill_count - 32'h1; // RULE18 RULE20
      fill_addr <= fill_addr + 32'h1;
      fill_pat <= {fill_pat[7:0], fill_pat[31:8]};
    end
  end

  // store port presents the current address and low pattern byte
  assign mem_address = fill_addr; // RULE18
  assign mem_byte = fill_pat[7:0];
endmodule

// *** hw/fcdu_pkg.sv ***
// constants, types and register map of the float convert and divide unit
package fcdu_pkg;
  // ==========================================================================
  // register map (byte offsets, one aligned word each)
  localparam logic [6:0] OFF_CMD     = 7'h00;
  localparam logic [6:0] OFF_OPA_LO  = 7'h04;
  localparam logic [6:0] OFF_OPA_HI  = 7'h08;
  localparam logic [6:0] OFF_OPB_LO  = 7'h0C;
  localparam logic [6:0] OFF_OPB_HI  = 7'h10;
  localparam logic [6:0] OFF_RES_LO  = 7'h14;
  localparam logic [6:0] OFF_RES_HI  = 7'h18;
  localparam logic [6:0] OFF_PSW     = 7'h1C;
  localparam logic [6:0] OFF_FLAGS   = 7'h20;
  localparam logic [6:0] OFF_TRAPEN  = 7'h24;
  localparam logic [6:0] OFF_PC      = 7'h28;
  localparam logic [6:0] OFF_FPPC    = 7'h2C;
  localparam logic [6:0] OFF_FPD_LO  = 7'h30;
  localparam logic [6:0] OFF_FPD_HI  = 7'h34;
  localparam logic [6:0] OFF_FCOUNT  = 7'h38;
  localparam logic [6:0] OFF_FADDR   = 7'h3C;
  localparam logic [6:0] OFF_FPAT    = 7'h40;
  // reset values
  localparam logic [4:0] TRAPEN_RST  = 5'h1F;
  localparam logic [1:0] PSW_RM_RST  = 2'h0;
  // ==========================================================================
  // operation codes written to the command register
  localparam logic [3:0] OP_CNVSD  = 4'h0;
  localparam logic [3:0] OP_CNVSW  = 4'h1;
  localparam logic [3:0] OP_CNVTSW = 4'h2;
  localparam logic [3:0] OP_CNVDW  = 4'h3;
  localparam logic [3:0] OP_CNVTDW = 4'h4;
  localparam logic [3:0] OP_CNVWD  = 4'h5;
  localparam logic [3:0] OP_CNVWS  = 4'h6;
  localparam logic [3:0] OP_DIVD   = 4'h7;
  localparam logic [3:0] OP_DIVS   = 4'h8;
  localparam logic [3:0] OP_DIVW   = 4'h9;
  localparam logic [3:0] OP_DIVWU  = 4'hA;
  localparam logic [3:0] OP_INITC  = 4'hB;
  // rounding modes in the processor_status_word field
  localparam logic [1:0] RM_NEAR = 2'h0;
  localparam logic [1:0] RM_UP   = 2'h1;
  localparam logic [1:0] RM_DOWN = 2'h2;
  localparam logic [1:0] RM_ZERO = 2'h3;
  // float flag positions: inexact, underflow, divzero, overflow, invalid
  localparam int FL_X = 0;
  localparam int FL_U = 1;
  localparam int FL_D = 2;
  localparam int FL_V = 3;
  localparam int FL_I = 4;
  // memory fault codes returned with a store
  localparam logic [1:0] MEM_OK = 2'h0;
  // ==========================================================================
  // arithmetic constants
  localparam logic signed [13:0] BIAS_D   = 14'sd1023;
  localparam logic signed [13:0] BIAS_S   = 14'sd127;
  localparam logic signed [13:0] EMIN_D   = -14'sd1022;
  localparam logic signed [13:0] EMIN_S   = -14'sd126;
  localparam logic signed [13:0] EMAXF_D  = 14'sd2047;
  localparam logic signed [13:0] EMAXF_S  = 14'sd255;
  localparam logic [63:0]        QNAN_D   = 64'h7FF8000000000000;
  localparam logic [31:0]        QNAN_S   = 32'h7FC00000;
  localparam logic [31:0]        INT_BAD  = 32'h80000000;
  localparam logic [6:0]         STEPS_INT = 7'd56;
  localparam logic [6:0]         STEPS_FLT = 7'd111;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_NORM = 3'b001,
    ST_DIV  = 3'b010,
    ST_FIN  = 3'b011,
    ST_FILL = 3'b100
  } fcdu_state_type;

  typedef struct packed {
    logic               sign;
    logic signed [13:0] exp;
    logic [55:0]        sig;
    logic               zero;
    logic               inf;
    logic               nan;
    logic               snan;
  } fcdu_unp_type;
endpackage

// *** tb/fcdu_props.sv ***
// assertion checker for the store port and register bus of fcdu_top
module fcdu_props
  import fcdu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] mem_address,
  input wire logic [7:0]  mem_byte,
  input wire logic        mem_write,
  input wire logic        mem_waitrequest,
  input wire logic [1:0]  mem_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ====
  // store and command events; a faulting store must leave the fill restartable
  sequence s_ok;
    mem_write && !mem_waitrequest && mem_fault == MEM_OK;
  endsequence
  sequence s_bad;
    mem_write && !mem_waitrequest && mem_fault != MEM_OK;
  endsequence
  sequence s_cnv;
    avs_write && !avs_waitrequest && avs_address[6:2] == OFF_CMD[6:2]
      && avs_writedata[3:0] < OP_INITC;
  endsequence
  a_fill_step: assert property (s_ok |=> !mem_write || mem_address == $past(mem_address) + 32'h1)
    else $error("fill address did not step");
  a_byte_cycle: assert property (s_ok [*4] ##1 mem_write |-> mem_byte == $past(mem_byte, 4))
    else $error("pattern rotation broken");
  a_stall_hold: assert property (mem_write && mem_waitrequest |=>
    mem_write && $stable(mem_address) && $stable(mem_byte))
    else $error("store dropped while stalled");
  a_fault_stop: assert property (s_bad |=> !mem_write)
    else $error("store after fault");
  a_fault_keep: assert property (s_bad |=> $stable(mem_address))
    else $error("address moved on fault");
  a_busy_stall: assert property (avs_write && mem_write |-> avs_waitrequest)
    else $error("write taken during fill");
  a_read_wait: assert property (avs_read && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  a_cnv_nostore: assert property (s_cnv |=> !mem_write [*8])
    else $error("store during arithmetic op");
endmodule
bind fcdu_top fcdu_props u_props (.*);

// *** tb/tb_float_convert_divide_unit.sv ***
// self-checking bench for fcdu_top
module tb_float_convert_divide_unit;
  import fcdu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        avs_waitrequest, mem_write, mem_waitrequest = 1'b0, stall = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_address, q, n_st = 32'h0;
  logic [31:0] flt_a = 32'hFFFF;
  logic [7:0]  mem_byte, mem [0:511];
  logic [1:0]  mem_fault;
  int          n_fail = 0, tests_run = 0;
  always #20 clk_sys = ~clk_sys;
  fcdu_top DUT (.*);
  // ====
  // memory: page fault at one chosen address, optional every-other-cycle stall
  assign mem_fault = (mem_address == flt_a) ? 2'h1 : 2'h0;
  always @(posedge clk_sys) begin
    mem_waitrequest <= stall & ~mem_waitrequest;
    if (mem_write && !mem_waitrequest && mem_fault == 2'h0) begin
      mem[mem_address[8:0]] <= mem_byte;
      n_st <= n_st + 32'h1;
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest && n < 2000);
    if (avs_waitrequest) begin
      n_fail++;
      print_verdict();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // the unmapped write stalls until the op is done
  task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
    bus(1'b1, OFF_OPA_LO, a);
    bus(1'b1, OFF_OPB_LO, b);
    bus(1'b1, OFF_CMD, {28'h0, c});
    bus(1'b1, 7'h7C, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    op(OP_DIVW, 32'h2, 32'hFFFFFFF9);
    rc(OFF_RES_LO, 32'hFFFFFFFD);
    rc(OFF_CMD, 32'h0);
    op(OP_DIVW, 32'hFFFFFFFF, 32'h80000000);
    rc(OFF_CMD, 32'h20);
    op(OP_DIVWU, 32'h2, 32'hFFFFFFFE);
    rc(OFF_RES_LO, 32'h7FFFFFFF);
    op(OP_DIVWU, 32'h0, 32'h5);
    rc(OFF_CMD, 32'h2002);
    op(OP_CNVWD, 32'hFFFFFFFD, 32'h0);
    rc(OFF_RES_HI, 32'hC0080000);
    rc(OFF_CMD, 32'h0);
    op(OP_CNVSD, 32'h3F800000, 32'h0);
    rc(OFF_RES_HI, 32'h3FF00000);
    // 2.5 under every rounding mode: only upward rounding gives 3
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFF_PSW, 32'(m));
      op(OP_CNVSW, 32'h40200000, 32'h0);
      rc(OFF_RES_LO, (m == 1) ? 32'h3 : 32'h2);
      op(OP_CNVTSW, 32'h40200000, 32'h0);
      rc(OFF_RES_LO, 32'h2);
    end
    rc(OFF_FLAGS, 32'h1);
    bus(1'b1, OFF_FLAGS, 32'h1F);
    op(OP_CNVWS, 32'h01000003, 32'h0);
    rc(OFF_RES_LO, 32'h4B800001);
    rc(OFF_FLAGS, 32'h1);
    bus(1'b1, OFF_FLAGS, 32'h1F);
    bus(1'b1, OFF_PC, 32'h1234);
    op(OP_CNVSW, 32'h7F800000, 32'h0);
    rc(OFF_FLAGS, 32'h10);
    rc(OFF_FPPC, 32'h1234);
    op(OP_DIVS, 32'h40000000, 32'h3F800000);
    rc(OFF_RES_LO, 32'h3F000000);
    bus(1'b1, OFF_OPA_HI, 32'h40100000);
    bus(1'b1, OFF_OPB_HI, 32'h3FF00000);
    op(OP_DIVD, 32'h0, 32'h0);
    rc(OFF_RES_HI, 32'h3FD00000);
    bus(1'b1, OFF_PC, 32'h00ABCD00);
    op(OP_DIVS, 32'h0, 32'h3F800000);
    rc(OFF_CMD, 32'h402);
    rc(OFF_FPPC, 32'h00ABCD00);
    rc(OFF_FPD_LO, 32'h3F800000);
    rc(7'h7C, 32'h0);
    // fill of 8 bytes with a stalling memory, page fault at the fourth byte
    stall <= 1'b1;
    flt_a <= 32'h103;
    bus(1'b1, OFF_FCOUNT, 32'h8);
    bus(1'b1, OFF_FADDR, 32'h100);
    bus(1'b1, OFF_FPAT, 32'h44332211);
    op(OP_INITC, 32'h0, 32'h0);
    rc(OFF_CMD, 32'h4002);
    rc(OFF_FCOUNT, 32'h5);
    rc(OFF_FADDR, 32'h103);
    rc(OFF_FPAT, 32'h33221144);
    chk({8'h00, mem[9'h102], mem[9'h101], mem[9'h100]}, 32'h00332211);
    stall <= 1'b0;
    flt_a <= 32'hFFFF;
    op(OP_INITC, 32'h0, 32'h0);
    chk({mem[9'h107], mem[9'h106], mem[9'h105], mem[9'h104]}, 32'h44332211);
    rc(OFF_FCOUNT, 32'h0);
    op(OP_INITC, 32'h0, 32'h0);
    chk(n_st, 32'h8);
    print_verdict();
  end
endmodule
